// [hw/adc_dma_regs.svh]
`ifndef ADC_DMA_REGS_SVH
`define ADC_DMA_REGS_SVH
`define XFER_EN_BIT        6
`define PWR_MODE_HI_BIT    7
`define PWR_MODE_LO_BIT    6
`define TMR_TRIG_BIT       1
`define EXT_TRIG_BIT       0
`define STOP_CODE          4'hF
`define PTR_RESET          24'h000000
`define PTR_STEP           24'h000002
`define CONV_TIME_NS       2380
`define CLK_PERIOD_NS      25
`define CONV_CYCLES        ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [hw/adc_dma_pkg.sv]
`default_nettype none
package adc_dma_pkg;
    // one word on the external data memory bus
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [23:0] addr;
        logic [7:0]  wdata;
    } xmem_req_type;
    // one converter result with its channel
    typedef struct packed {
        logic [3:0]  chan;
        logic [11:0] value;
    } result_type;
endpackage : adc_dma_pkg
`default_nettype wire

// [hw/result_buffer.sv]
`default_nettype none
module result_buffer
    import adc_dma_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
)(
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic [WIDTH-1:0] rdata_q;
    logic             rvalid_q;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = (cnt_q != '0) && (!rvalid_q || out_ready_i);

    // ====================================================
    // handshake and output register
    assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = rvalid_q;
    assign out_data_o  = rdata_q;

    // storage with registered read stage
    always_ff @(posedge clock_i)
    begin
        if (push)
            mem_q[wp_q] <= in_data_i;
        if (pop)
            rdata_q <= mem_q[rp_q];
        if (rst_i)
        begin
            wp_q     <= '0;
            rp_q     <= '0;
            cnt_q    <= '0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            if (push)
                wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
            if (pop)
                rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
            if (pop)
                rvalid_q <= 1'b1;
            else if (out_ready_i)
                rvalid_q <= 1'b0;
        end
    end
endmodule : result_buffer
`default_nettype wire

// [hw/adc_result_dma.sv]
`include "adc_dma_regs.svh"
`default_nettype none
module adc_result_dma
    import adc_dma_pkg::*;
#(
    parameter int CONV_CYCLES = `CONV_CYCLES
)(
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // register writes from the core, then start and trigger inputs
    input  wire logic        ctrl_first_we_i,
    input  wire logic        ctrl_second_we_i,
    input  wire logic        ptr_low_we_i,
    input  wire logic        ptr_high_we_i,
    input  wire logic        ptr_page_we_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        soft_start_i,
    input  wire logic        timer2_trig_i,
    input  wire logic        ext_trig_i,
    // core access to external memory
    input  wire logic        core_xmem_rd_i,
    input  wire logic        core_xmem_wr_i,
    input  wire logic [23:0] core_xmem_addr_i,
    input  wire logic [7:0]  core_xmem_wdata_i,
    output logic [7:0]       core_xmem_rdata_o,
    // converter
    output logic             conv_start_o,
    output logic [3:0]       conv_chan_o,
    input  wire logic        conv_done_i,
    input  wire logic [11:0] conv_result_i,
    // external RAM bus, one-cycle access
    output logic             xmem_rd_o,
    output logic             xmem_wr_o,
    output logic [23:0]      xmem_addr_o,
    output logic [7:0]       xmem_wdata_o,
    input  wire logic [7:0]  xmem_rdata_i,
    // status, and done flag clear
    output logic [7:0]       conv_ctrl_first_o,
    output logic [7:0]       conv_ctrl_second_o,
    output logic [23:0]      xfer_ptr_o,
    output logic             xfer_active_o,
    output logic             conv_power_up_o,
    output logic             conv_done_flag_o,
    input  wire logic        conv_done_flag_clr_i
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_PEEK, ST_PEEK_WAIT, ST_ARM, ST_CONVERT
    } dma_state_type;

    dma_state_type state_q, state_d;
    logic [7:0]  first_q, second_q;
    logic [23:0] ptr_q;
    logic [23:0] wr_ptr_q;
    logic [3:0]  chan_q;
    logic        flag_q;
    logic        ext_s1_q, ext_s2_q, ext_s3_q;
    logic        cmd_q;
    logic        ended_q;
    result_type  buf_out;
    logic        buf_valid, buf_in_ready, buf_pop;
    xmem_req_type dma_req;
    xmem_req_type bus_q;

    // ====================================================
    // decoding
    function automatic logic is_stop(input logic [7:0] b);
        is_stop = (b[7:4] == `STOP_CODE);
    endfunction : is_stop

    wire xfer_en   = second_q[`XFER_EN_BIT];
    wire power_up  = first_q[`PWR_MODE_HI_BIT] | first_q[`PWR_MODE_LO_BIT];
    wire ext_rise  = ext_s2_q & ~ext_s3_q;
    wire trig      = soft_start_i
                   | (timer2_trig_i & first_q[`TMR_TRIG_BIT])
                   | (ext_rise & first_q[`EXT_TRIG_BIT]);
    wire fetch_stop = is_stop(xmem_rdata_i);
    // stop seen on the fetched id or on the one after it
    wire stop_seen  = ((state_q == ST_PEEK) || (state_q == ST_PEEK_WAIT)) && fetch_stop;

    // ====================================================
    // core writable registers and pointer
    // 24-bit pointer carry
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            first_q  <= 8'h00;
            second_q <= 8'h00;
            ptr_q    <= `PTR_RESET;
        end
        else
        begin
            if (ctrl_first_we_i)
                first_q <= reg_wdata_i;
            if (ctrl_second_we_i)
                second_q <= reg_wdata_i;
            if (ptr_low_we_i)
                ptr_q[7:0] <= reg_wdata_i;
            else if (ptr_high_we_i)
                ptr_q[15:8] <= reg_wdata_i;
            else if (ptr_page_we_i)
                ptr_q[23:16] <= reg_wdata_i;
            else if (state_q == ST_CONVERT && conv_done_i)
                ptr_q <= ptr_q + `PTR_STEP;
        end
    end

    // external trigger pin sync then edge
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            {ext_s1_q, ext_s2_q, ext_s3_q} <= 3'b000;
        else
            {ext_s1_q, ext_s2_q, ext_s3_q} <= {ext_trig_i, ext_s1_q, ext_s2_q};
    end

    // ====================================================
    // sequence machine
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            // a finished sequence waits for transfer enable to drop
            ST_IDLE:       if (xfer_en && power_up && !ended_q) state_d = ST_FETCH;
            ST_FETCH:      state_d = ST_PEEK;
            // id before the stop code is never converted
            ST_PEEK:       state_d = fetch_stop ? ST_IDLE : ST_PEEK_WAIT;
            ST_PEEK_WAIT:  state_d = fetch_stop ? ST_IDLE : ST_ARM;
            ST_ARM:        if (trig && !cmd_q) state_d = ST_CONVERT;
            ST_CONVERT:    if (conv_done_i) state_d = ST_FETCH;
            default:       state_d = ST_IDLE;
        endcase
        if (!xfer_en)
            state_d = ST_IDLE;
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            state_q <= ST_IDLE;
            chan_q  <= 4'h0;
            cmd_q   <= 1'b0;
            ended_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (state_q == ST_PEEK)
                chan_q <= xmem_rdata_i[7:4];
            if (!xfer_en)
                ended_q <= 1'b0;
            else if (stop_seen)
                ended_q <= 1'b1;
            // hold off a new start while a previous word waits on the bus
            cmd_q <= buf_valid;
        end
    end

    // done flag, set wins over clear
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            flag_q <= 1'b0;
        else if (stop_seen && xfer_en)
            flag_q <= 1'b1;
        else if (conv_done_flag_clr_i)
            flag_q <= 1'b0;
    end

    // ====================================================
    // result buffer: the fetch of the next id never waits on a store
    // a buffered result holds off the next start until stored
    result_buffer #(
        .WIDTH ($bits(result_type)),
        .DEPTH (2)
    ) u_buf (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .in_valid_i  (state_q == ST_CONVERT && conv_done_i),
        .in_ready_o  (buf_in_ready),
        .in_data_i   ({chan_q, conv_result_i}),
        .out_valid_o (buf_valid),
        .out_ready_i (buf_pop),
        .out_data_o  (buf_out)
    );

    // store two bytes: id nibble with result top, then low byte
    logic store_lo_q;
    wire  bus_free = !((state_q == ST_FETCH) || (state_q == ST_PEEK));
    assign buf_pop = buf_valid && bus_free && store_lo_q;
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            store_lo_q <= 1'b0;
            wr_ptr_q   <= `PTR_RESET;
        end
        else
        begin
            if (state_q == ST_CONVERT && conv_done_i)
                wr_ptr_q <= ptr_q;
            if (buf_valid && bus_free)
                store_lo_q <= ~store_lo_q;
        end
    end

    // stop fields only read, never written
    always_comb
    begin
        dma_req = '0;
        if (state_q == ST_FETCH)
        begin
            dma_req.rd   = 1'b1;
            dma_req.addr = ptr_q;
        end
        else if (state_q == ST_PEEK)
        begin
            dma_req.rd   = 1'b1;
            dma_req.addr = ptr_q + `PTR_STEP;
        end
        else if (buf_valid)
        begin
            dma_req.wr    = 1'b1;
            dma_req.addr  = store_lo_q ? wr_ptr_q + 24'h000001 : wr_ptr_q;
            dma_req.wdata = store_lo_q ? buf_out.value[7:0]
                                       : {buf_out.chan, buf_out.value[11:8]};
        end
    end

    // core accesses dropped in transfer mode
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            bus_q <= '0;
        else if (xfer_en || buf_valid)
            bus_q <= dma_req;
        else
            bus_q <= '{rd: core_xmem_rd_i, wr: core_xmem_wr_i,
                       addr: core_xmem_addr_i, wdata: core_xmem_wdata_i};
    end

    // ====================================================
    // outputs
    assign xmem_rd_o          = dma_req.rd | (!xfer_en && !buf_valid && bus_q.rd);
    assign xmem_wr_o          = dma_req.wr | (!xfer_en && !buf_valid && bus_q.wr);
    assign xmem_addr_o        = (xfer_en || buf_valid) ? dma_req.addr : bus_q.addr;
    assign xmem_wdata_o       = (xfer_en || buf_valid) ? dma_req.wdata : bus_q.wdata;
    assign core_xmem_rdata_o  = xfer_en ? 8'hFF : xmem_rdata_i;
    assign conv_start_o       = (state_q == ST_ARM) && trig && !cmd_q;
    assign conv_chan_o        = chan_q;
    assign conv_ctrl_first_o  = first_q;
    assign conv_ctrl_second_o = second_q;
    assign xfer_ptr_o         = ptr_q;
    assign xfer_active_o      = (state_q != ST_IDLE);
    assign conv_power_up_o    = power_up;
    assign conv_done_flag_o   = flag_q;
endmodule : adc_result_dma
`default_nettype wire

// [dv/adc_dma_asserts.sv]
`default_nettype none
// ==========
// port checker for the transfer engine
module adc_dma_asserts (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        conv_done_i,
    input wire logic        conv_start_o,
    input wire logic        xmem_rd_o,
    input wire logic        xmem_wr_o,
    input wire logic [23:0] xmem_addr_o,
    input wire logic [7:0]  xmem_rdata_i,
    input wire logic [7:0]  core_xmem_rdata_o,
    input wire logic [7:0]  conv_ctrl_second_o,
    input wire logic [23:0] xfer_ptr_o,
    input wire logic        xfer_active_o,
    input wire logic        conv_power_up_o,
    input wire logic        conv_done_flag_o,
    input wire logic        conv_done_flag_clr_i
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // core reads see a dead bus while transfer mode holds it
    a_core_shut_out: assert property (conv_ctrl_second_o[6] |-> core_xmem_rdata_o == 8'hFF)
        else $error("core read reached memory");
    a_ptr_step: assert property (conv_done_i && xfer_active_o |=>
        xfer_ptr_o == $past(xfer_ptr_o) + 24'h000002) else $error("pointer step");
    a_fetch_at_ptr: assert property (xmem_rd_o && conv_ctrl_second_o[6] && !$past(xmem_rd_o) |->
        xmem_addr_o == xfer_ptr_o) else $error("fetch address");
    a_peek_ahead: assert property (xmem_rd_o && conv_ctrl_second_o[6] && $past(xmem_rd_o) |->
        xmem_addr_o == xfer_ptr_o + 24'h000002) else $error("look-ahead address");
    a_stop_flags: assert property (xmem_rd_o && conv_ctrl_second_o[6] ##1
        xmem_rdata_i[7:4] == 4'hF |=> conv_done_flag_o) else $error("stop missed");
    a_flag_holds: assert property (conv_done_flag_o && !conv_done_flag_clr_i |=>
        conv_done_flag_o) else $error("flag dropped");
    a_start_armed: assert property (conv_start_o |->
        conv_power_up_o && conv_ctrl_second_o[6]) else $error("start unarmed");
    a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
        else $error("start too long");
    a_bus_single: assert property (xmem_wr_o |-> !xmem_rd_o)
        else $error("bus clash");
endmodule : adc_dma_asserts
bind adc_result_dma adc_dma_asserts chk (.*);
`default_nettype wire

// [dv/xram_model.sv]
`default_nettype none
// ==========
// external static RAM, read data one cycle after the strobe
module xram_model (
    input  wire logic        clock_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    output logic [7:0]       rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [int];
    initial rdata_o = 8'h5A;
    // ids kept where software preloaded them
    // bus floats between reads: a toggling pattern, never a held value
    always @(posedge clock_i)
    begin
        if (wr_i)
            mem[addr_i] = wdata_i;
        if (rd_i && mem.exists(addr_i))
            rdata_o <= mem[addr_i];
        else
            rdata_o <= ~rdata_o;
    end
endmodule : xram_model
`default_nettype wire

// [dv/tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LAT = 80; // converter busy time, inside one 96-cycle slot
    logic clock_i = 0, rst_i = 1, soft_start_i = 0, timer2_trig_i = 0, ext_trig_i = 0;
    logic ctrl_first_we_i = 0, ctrl_second_we_i = 0, ptr_low_we_i = 0, ptr_high_we_i = 0;
    logic ptr_page_we_i = 0, core_xmem_rd_i = 0, core_xmem_wr_i = 0, conv_done_flag_clr_i = 0;
    logic conv_done_i = 0, conv_start_o, xmem_rd_o, xmem_wr_o, xfer_active_o, conv_power_up_o;
    logic [7:0] reg_wdata_i = 0, core_xmem_wdata_i = 0, core_xmem_rdata_o, xmem_wdata_o;
    logic [7:0] xmem_rdata_i, conv_ctrl_first_o, conv_ctrl_second_o;
    logic [23:0] core_xmem_addr_i = 0, xmem_addr_o, xfer_ptr_o;
    logic [11:0] conv_result_i = 0;
    logic [3:0] conv_chan_o, ch = 0;
    logic conv_done_flag_o;
    int err_count = 0, check_count = 0, busy = 0, n_done = 0;
    adc_result_dma #(.CONV_CYCLES(LAT)) dut (.*);
    xram_model ram (.clock_i(clock_i), .rd_i(xmem_rd_o), .wr_i(xmem_wr_o),
        .addr_i(xmem_addr_o), .wdata_i(xmem_wdata_o), .rdata_o(xmem_rdata_i));
    initial forever #12.5 clock_i = ~clock_i;
    // converter stand-in: result carries channel and running sample count
    always @(posedge clock_i)
    begin
        if (conv_start_o) {busy, ch} <= {LAT, conv_chan_o};
        else if (busy > 0) busy <= busy - 1;
        conv_done_i <= (busy == 1);
        conv_result_i <= {ch ^ 4'hC, n_done[7:0]};
        if (busy == 1) n_done <= n_done + 1;
    end
    // ==========
    // shared drivers and checks
    task automatic tick; @(posedge clock_i); #1; endtask : tick
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse(ref logic s); s = 1; tick(); s = 0; tick(); endtask : pulse
    task automatic wait_hi(ref logic s); // bounded wait for a design answer
        for (int t = 0; t < 300 && s !== 1'b1; t++) tick();
        tick();
    endtask : wait_hi
    task automatic wreg(input int sel, input logic [7:0] v);
        reg_wdata_i = v;
        {ctrl_first_we_i, ctrl_second_we_i, ptr_low_we_i, ptr_high_we_i, ptr_page_we_i} =
            5'b10000 >> sel;
        tick();
        {ctrl_first_we_i, ctrl_second_we_i, ptr_low_we_i, ptr_high_we_i, ptr_page_we_i} = 0;
        tick();
    endtask : wreg
    // software setup: power down, pointer, memory image, then enable and power up
    task automatic setup(input logic [23:0] b, input logic [3:0] id[$], input logic [7:0] f);
        wreg(1, 8'h00);
        wreg(0, 8'h00);
        pulse(conv_done_flag_clr_i);
        wreg(2, b[7:0]);
        wreg(3, b[15:8]);
        wreg(4, b[23:16]);
        id.push_back(id[$]);
        id.push_back(4'hF);
        foreach (id[i]) {ram.mem[b + 2 * i], ram.mem[b + 2 * i + 1]} = {id[i], 12'h0EE};
        wreg(1, 8'h40);
        wreg(0, f);
    endtask : setup
    task automatic verify(input logic [23:0] b, input logic [3:0] id[$], input int n0);
        int k;
        wait_hi(conv_done_flag_o);
        chk(conv_done_flag_o, 1);
        for (k = 0; k < id.size(); k++)
        begin
            chk(ram.mem[b + 2 * k], {id[k], id[k] ^ 4'hC});
            chk(ram.mem[b + 2 * k + 1], 8'(n0 + k));
        end
        chk(ram.mem[b + 2 * k], {id[k - 1], 4'h0});
        chk(ram.mem[b + 2 * k + 3], 8'hEE);
    endtask : verify
    // ==========
    // scenarios
    task automatic soft_run; // results straddle the page carry
        int n0 = n_done;
        setup(24'h01FFFE, '{4'h3, 4'h7}, 8'hC0);
        repeat (2)
        begin
            repeat (8) tick();
            pulse(soft_start_i);
            wait_hi(conv_done_i);
        end
        verify(24'h01FFFE, '{4'h3, 4'h7}, n0);
    endtask : soft_run
    task automatic timer_run; // full rate with core traffic kept off the bus
        int n0 = n_done;
        ram.mem[24'h000050] = 8'h11;
        setup(24'h000100, '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5}, 8'hC2);
        repeat (6)
        begin
            repeat (4) tick();
            pulse(timer2_trig_i);
            {core_xmem_addr_i, core_xmem_wdata_i, core_xmem_wr_i} = {24'h000050, 8'h33, 1'b1};
            tick();
            {core_xmem_wr_i, core_xmem_rd_i} = 2'b01;
            tick();
            chk(core_xmem_rdata_o, 8'hFF);
            core_xmem_rd_i = 0;
            repeat (88) tick();
        end
        verify(24'h000100, '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5}, n0);
        chk(ram.mem[24'h000050], 8'h11);
    endtask : timer_run
    task automatic ext_run; // top of the address space, then refusal when idle
        int n0 = n_done;
        setup(24'hFFFFF0, '{4'h9}, 8'hC1);
        repeat (4) tick();
        ext_trig_i = 1;
        repeat (6) tick();
        ext_trig_i = 0;
        verify(24'hFFFFF0, '{4'h9}, n0);
        pulse(conv_done_flag_clr_i);
        chk(conv_done_flag_o, 0);
        wreg(1, 8'h00);
        pulse(soft_start_i);
        pulse(timer2_trig_i);
        repeat (100) tick();
        chk(n_done, n0 + 1);
        {core_xmem_addr_i, core_xmem_wdata_i, core_xmem_wr_i} = {24'h000060, 8'h44, 1'b1};
        tick();
        core_xmem_wr_i = 0;
        tick();
        chk(ram.mem[24'h000060], 8'h44);
    endtask : ext_run
    task automatic give_verdict;
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // watchdog well past the roughly 1000 cycles the scenarios need
    initial
    begin
        #200000;
        err_count++;
        give_verdict();
    end
    initial
    begin
        repeat (2) @(posedge clock_i);
        #1 rst_i = 0;
        soft_run();
        timer_run();
        ext_run();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
